// ==== test/ebcp_mem_model.sv ====
// Purpose: External memory answering read strobes
// Assumes: Read data is low address half xor 16'h5a3c
// Notes:   Undriven bus toggles every cycle
module ebcp_mem_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        rd_n_i,
	input  wire logic [3:0]  cs_n_i,
	input  wire logic [23:0] addr_i,
	input  wire logic        slow_i,
	output logic      [15:0] data_o
);
	logic [1:0] cnt_q;
	// ==========================================================
	// Drive while selected and strobed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q  <= '0;
			data_o <= '0;
		end else if (!rd_n_i && cs_n_i != 4'hf) begin
			cnt_q  <= cnt_q + 2'(cnt_q != 2'h3);
			data_o <= (cnt_q >= {1'b0, slow_i}) ? (addr_i[15:0] ^ 16'h5a3c) : ~data_o;
		end else begin
			cnt_q  <= '0;
			data_o <= ~data_o;
		end
	end
endmodule

// ==== test/ebcp_phaser_properties.sv ====
// Purpose: Bus pin properties of the cycle phaser
// Assumes: One cpu_clock_period is two MCLK_I cycles
// Notes:   Bound to ebcp_phaser below
module ebcp_chk (
	input wire logic       MCLK_I,
	input wire logic       SYS_RST_I,
	input wire logic       BUS_REF_CLK_O,
	input wire logic       BUS_ALE_O,
	input wire logic       BUS_RD_N_O,
	input wire logic       BUS_WR_N_O,
	input wire logic       BUS_DATA_OE_O,
	input wire logic [3:0] BUS_CS_N_O
);
	// ==========================================================
	// Pin properties
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (SYS_RST_I);
	a_pins_on_ref: assert property (($changed(BUS_ALE_O) || $changed(BUS_RD_N_O) ||
		$changed(BUS_WR_N_O) || $changed(BUS_CS_N_O) || $changed(BUS_DATA_OE_O))
		|-> $rose(BUS_REF_CLK_O)) else $error("pin moved off reference rise");
	a_ref_period: assert property (!BUS_REF_CLK_O |=> BUS_REF_CLK_O)
		else $error("reference clock low too long");
	a_strobe_after_ale: assert property (($fell(BUS_RD_N_O) || $fell(BUS_WR_N_O))
		|-> !BUS_ALE_O && BUS_CS_N_O != 4'hf) else $error("strobe before setup end");
	a_ab_min: assert property ($rose(BUS_ALE_O) |-> BUS_ALE_O[*2])
		else $error("address setup too short");
	a_ab_max: assert property ($rose(BUS_ALE_O) |-> ##[2:10] !BUS_ALE_O)
		else $error("address setup too long");
	a_access_min: assert property ($fell(BUS_WR_N_O) |-> !BUS_WR_N_O[*2])
		else $error("access too short");
	a_access_max: assert property ($fell(BUS_RD_N_O) |-> ##[2:64] BUS_RD_N_O)
		else $error("access too long");
	a_oe_on_write: assert property (!BUS_WR_N_O |-> BUS_DATA_OE_O && BUS_RD_N_O)
		else $error("write data not driven");
	a_hold_bound: assert property (($rose(BUS_RD_N_O) || $rose(BUS_WR_N_O))
		|-> ##[0:6] BUS_CS_N_O == 4'hf) else $error("hold phase too long");
endmodule

bind ebcp_phaser ebcp_chk i_chk (.MCLK_I, .SYS_RST_I, .BUS_REF_CLK_O, .BUS_ALE_O,
	.BUS_RD_N_O, .BUS_WR_N_O, .BUS_DATA_OE_O, .BUS_CS_N_O);

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench of the cycle phaser
// Assumes: Register map of ebcp_pkg
// Notes:   Pin monitor measures phases in MCLK_I cycles
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("wrong value at %0t: got %0h exp %0h", $time, g, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ebcp_pkg::*;
	typedef struct {int ab; int cd; int e; int f; logic wr; logic [1:0] cs;
		logic [23:0] addr; logic [15:0] data;} ebcp_exp_t;
	logic        clk = 0, rst = 1, slow = 0, first = 1, in_cyc = 0;
	logic [7:0]  awaddr = '0, araddr = '0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = '0, rdata, rnd = 32'hf165;
	logic        awready, wready, bvalid, arready, rvalid, ref_clk, oe, rd_n, wr_n, ale;
	logic [1:0]  bresp, rresp, prev_cs = '0;
	logic [23:0] baddr, s_addr;
	logic [15:0] bdata, din, s_data;
	logic [3:0]  cs_n, s_cs;
	int          errors = 0, total_checks = 0, n_ab = 0, n_cd = 0, n_e = 0, n_f = 0;
	ebcp_exp_t   expq[$];
	ebcp_exp_t   mx;

	ebcp_phaser i_dut (.MCLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .BUS_REF_CLK_O(ref_clk), .BUS_ADDR_O(baddr),
		.BUS_DATA_O(bdata), .BUS_DATA_OE_O(oe), .BUS_DATA_I(din), .BUS_RD_N_O(rd_n),
		.BUS_WR_N_O(wr_n), .BUS_ALE_O(ale), .BUS_CS_N_O(cs_n));
	ebcp_mem_model i_mem (.clk_i(clk), .rst_i(rst), .rd_n_i(rd_n), .cs_n_i(cs_n),
		.addr_i(baddr), .slow_i(slow), .data_o(din));

	initial begin
		forever #4 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// ==========================================================
	// Register bus master
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		bit aw = 0;
		bit w = 0;
		@(posedge clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (!aw && awready) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		`CHK(bresp, (a == 8'h14) ? RESP_ERR : RESP_OK)
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		`CHK(d, e)
		`CHK(r, er)
	endtask

	// ==========================================================
	// One bus cycle with minimum, maximum or random timing
	task automatic run_cycle(input int k);
		ebcp_exp_t   x;
		logic [31:0] cfg, d;
		logic [1:0]  r;
		rnd = lfsr(rnd);
		x.wr = (k == 0) ? 1'b1 : (k == 1) ? 1'b0 : rnd[0];
		x.cs = (k == 1) ? prev_cs + 2'h1 : k[0] ? prev_cs : rnd[2:1];
		cfg = (k == 0) ? 32'h0 : (k == 1) ? 32'h1fff : {19'h0, rnd[15:3]};
		if (!x.wr && cfg[10:6] < 5'd4) cfg[10:6] = 5'd4;
		x.ab = 1 + cfg[0] + ((first || x.cs != prev_cs) ? cfg[2:1] : 0);
		x.cd = cfg[4:3] + cfg[5];
		x.e = cfg[10:6] + 1;
		x.f = cfg[12:11];
		x.addr = rnd[31:8];
		x.data = rnd[23:8];
		slow <= k[1];
		axi_wr(OFS_TCFG0 + 8'(4 * x.cs), cfg);
		axi_wr(OFS_ADDR, {8'h0, x.addr});
		axi_wr(OFS_WDATA, {16'h0, x.data});
		expq.push_back(x);
		axi_wr(OFS_CMD, {29'h0, x.cs, x.wr});
		do axi_rd(OFS_STATUS, d, r); while (d[ST_DONE_BIT] !== 1'b1);
		if (!x.wr) rd_chk(OFS_RDATA, {16'h0, x.addr[15:0] ^ 16'h5a3c}, RESP_OK);
		axi_wr(OFS_STATUS, 32'h2);
		rd_chk(OFS_STATUS, 32'h0, RESP_OK);
		prev_cs = x.cs;
		first = 0;
	endtask

	// ==========================================================
	// Pin monitor
	always @(posedge clk) begin
		if (rst) begin
			in_cyc = 0;
		end else if (cs_n != 4'hf) begin
			in_cyc = 1;
			if (ale) begin
				n_ab++;
				s_addr = baddr;
			end else if (rd_n && wr_n && n_e == 0) n_cd++;
			else if (!rd_n || !wr_n) begin
				n_e++;
				s_data = bdata;
				s_cs = ~cs_n;
			end else n_f++;
		end else if (in_cyc) begin
			mx = expq.pop_front();
			`CHK(n_ab, 2 * mx.ab)
			`CHK(n_cd, 2 * mx.cd)
			`CHK(n_e, 2 * mx.e)
			`CHK(n_f, 2 * mx.f)
			`CHK(s_cs, 4'h1 << mx.cs)
			`CHK(s_addr, mx.addr)
			if (mx.wr) `CHK(s_data, mx.data)
			in_cyc = 0;
			n_ab = 0;
			n_cd = 0;
			n_e = 0;
			n_f = 0;
		end
	end

	task automatic tally_and_finish();
		if (errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		tally_and_finish();
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) rd_chk(OFS_TCFG0 + 8'(4 * i), 32'(TCFG_RST), RESP_OK);
		axi_wr(8'h14, 32'hffff_ffff);
		rd_chk(8'h14, 32'h0, RESP_ERR);
		for (int k = 0; k < 8; k++) run_cycle(k);
		repeat (4) @(posedge clk);
		tally_and_finish();
	end
endmodule

// ==== verilog/ebcp_phaser.sv ====
// Purpose: External bus cycle phaser with AXI4-Lite register access
// Assumes: MCLK_I at 125 MHz, synchronous active-high SYS_RST_I
// Notes:   Bus outputs change only with rising bus_reference_clock_out
//
// Overview of operation
// - Each bus cycle runs address setup, command delay, data setup, access, hold in order.
// - Phase lengths come from the timing configuration of the selected chip select.
// - Address setup is 1 to 2 periods, plus 0 to 3 when the chip select changed.
// - Write data setup or tristate phase is 0 or 1 period.
// - Address and write data hold phase is 0 to 3 periods.
// - Command delay is 0 to 3 periods and access 1 to 32 periods.
// - Read data is captured on the edge that ends the read strobe.
// - All bus outputs change with rising edges of the reference clock output.
module ebcp_phaser (
	input  wire logic                      MCLK_I,
	input  wire logic                      SYS_RST_I,
	input  wire logic [ebcp_pkg::AXI_AW-1:0] S_AXI_AWADDR_I,
	input  wire logic                      S_AXI_AWVALID_I,
	output logic                           S_AXI_AWREADY_O,
	input  wire logic [31:0]               S_AXI_WDATA_I,
	input  wire logic [3:0]                S_AXI_WSTRB_I,
	input  wire logic                      S_AXI_WVALID_I,
	output logic                           S_AXI_WREADY_O,
	output logic [1:0]                     S_AXI_BRESP_O,
	output logic                           S_AXI_BVALID_O,
	input  wire logic                      S_AXI_BREADY_I,
	input  wire logic [ebcp_pkg::AXI_AW-1:0] S_AXI_ARADDR_I,
	input  wire logic                      S_AXI_ARVALID_I,
	output logic                           S_AXI_ARREADY_O,
	output logic [31:0]                    S_AXI_RDATA_O,
	output logic [1:0]                     S_AXI_RRESP_O,
	output logic                           S_AXI_RVALID_O,
	input  wire logic                      S_AXI_RREADY_I,
	output logic                           BUS_REF_CLK_O,
	output logic [ebcp_pkg::ADDR_W-1:0]    BUS_ADDR_O,
	output logic [ebcp_pkg::DATA_W-1:0]    BUS_DATA_O,
	output logic                           BUS_DATA_OE_O,
	input  wire logic [ebcp_pkg::DATA_W-1:0] BUS_DATA_I,
	output logic                           BUS_RD_N_O,
	output logic                           BUS_WR_N_O,
	output logic                           BUS_ALE_O,
	output logic [ebcp_pkg::NUM_CS-1:0]    BUS_CS_N_O
);
	import ebcp_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		ebcp_phase_t              ph;
		logic [5:0]               cnt;
		logic [TCP_CYCLES-1:0]    div;
		logic                     ref_clk;
		logic                     go;
		logic                     done;
		logic                     last_vld;
		logic [1:0]               last_cs;
		logic [1:0]               cs;
		logic                     dir;
		logic [ADDR_W-1:0]        addr;
		logic [DATA_W-1:0]        wdata;
		logic [DATA_W-1:0]        rdata;
		logic [NUM_CS-1:0][CFG_W-1:0] tcfg;
		logic                     aw_full;
		logic [AXI_AW-1:0]        aw_addr;
		logic                     w_full;
		logic [31:0]              w_data;
		logic [3:0]               w_strb;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     rvalid;
		logic [31:0]              rdata_bus;
		logic [1:0]               rresp;
		logic                     aw_rdy;
		logic                     w_rdy;
		logic                     ar_rdy;
		logic [ADDR_W-1:0]        p_addr;
		logic [DATA_W-1:0]        p_data;
		logic                     p_oe;
		logic                     p_rd_n;
		logic                     p_wr_n;
		logic                     p_ale;
		logic [NUM_CS-1:0]        p_cs_n;
	} ebcp_state_t;

	ebcp_state_t s_q;
	ebcp_state_t s_d;

	logic [DATA_W-1:0] din_sync;

	// ==========================================================
	// Read data synchroniser
	ebcp_sync #(
		.W (SYNC_W)
	) u_din_sync (
		.clk_i   (MCLK_I),
		.rst_i   (SYS_RST_I),
		.async_i (BUS_DATA_I),
		.sync_o  (din_sync)
	);

	// ==========================================================
	// Byte-lane merge
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Next state
	logic [CFG_W-1:0] cfg;
	logic [5:0]       len_ab;
	logic [5:0]       len_c;
	logic [5:0]       len_d;
	logic [5:0]       len_e;
	logic [5:0]       len_f;
	logic             tick;
	logic             wr_fire;
	logic [31:0]      wval;
	logic [31:0]      rval;
	logic             rmap;
	logic             wmap;

	always_comb begin
		s_d     = s_q;
		cfg     = s_q.tcfg[s_q.cs];
		// Phase lengths in cpu_clock_period units, AB and E minus one
		len_ab  = 6'(cfg[CFG_AB_BIT]) + ((!s_q.last_vld || (s_q.last_cs != s_q.cs)) ?
			6'(cfg[CFG_ABX_LSB +: 2]) : 6'h00);
		len_c   = 6'(cfg[CFG_C_LSB +: 2]);
		len_d   = 6'(cfg[CFG_D_BIT]);
		len_e   = 6'(cfg[CFG_E_LSB +: 5]);
		len_f   = 6'(cfg[CFG_F_LSB +: 2]);
		tick    = (s_q.div == '0);
		wr_fire = 1'b0;
		wval    = 32'h0;
		rval    = 32'h0;
		rmap    = 1'b1;
		wmap    = 1'b1;

		// Reference clock divider
		s_d.div     = (32'(s_q.div) == TCP_CYCLES - 1) ? '0 : s_q.div + 1'b1;
		s_d.ref_clk = tick ? 1'b1 : 1'b0;

		// Phase sequencer, advanced once per period
		if (tick) begin
			case (s_q.ph)
				PH_IDLE: begin
					if (s_q.go) begin
						s_d.go       = 1'b0;
						s_d.last_vld = 1'b1;
						s_d.last_cs  = s_q.cs;
						s_d.ph       = PH_AB;
						s_d.cnt      = len_ab;
					end
				end
				PH_AB, PH_C, PH_D, PH_E, PH_F: begin
					if (s_q.cnt != 6'h00) begin
						s_d.cnt = s_q.cnt - 6'h01;
					end else begin
						case (s_q.ph)
							PH_AB: begin
								if (len_c != 6'h00) begin
									s_d.ph  = PH_C;
									s_d.cnt = len_c - 6'h01;
								end else if (len_d != 6'h00) begin
									s_d.ph  = PH_D;
									s_d.cnt = 6'h00;
								end else begin
									s_d.ph  = PH_E;
									s_d.cnt = len_e;
								end
							end
							PH_C: begin
								if (len_d != 6'h00) begin
									s_d.ph  = PH_D;
									s_d.cnt = 6'h00;
								end else begin
									s_d.ph  = PH_E;
									s_d.cnt = len_e;
								end
							end
							PH_D: begin
								s_d.ph  = PH_E;
								s_d.cnt = len_e;
							end
							PH_E: begin
								if (!s_q.dir) begin
									s_d.rdata = din_sync;
								end
								if (len_f != 6'h00) begin
									s_d.ph  = PH_F;
									s_d.cnt = len_f - 6'h01;
								end else begin
									s_d.ph   = PH_IDLE;
									s_d.done = 1'b1;
								end
							end
							default: begin
								s_d.ph   = PH_IDLE;
								s_d.done = 1'b1;
							end
						endcase
					end
				end
				default: begin
					s_d.ph = PH_IDLE;
				end
			endcase
		end

		// Pin values follow the phase, so they move only on ticks
		s_d.p_ale  = (s_d.ph == PH_AB);
		s_d.p_rd_n = !((s_d.ph == PH_E) && !s_q.dir);
		s_d.p_wr_n = !((s_d.ph == PH_E) && s_q.dir);
		s_d.p_oe   = s_q.dir && ((s_d.ph == PH_D) || (s_d.ph == PH_E) ||
			(s_d.ph == PH_F));
		s_d.p_cs_n = '1;
		if (s_d.ph != PH_IDLE) begin
			s_d.p_cs_n[s_q.cs] = 1'b0;
		end
		if (tick && (s_q.ph == PH_IDLE) && s_q.go) begin
			s_d.p_addr = s_q.addr;
			s_d.p_data = s_q.wdata;
		end

		// ======================================================
		// AXI4-Lite write channel
		if (S_AXI_AWVALID_I && !s_q.aw_full) begin
			s_d.aw_full = 1'b1;
			s_d.aw_addr = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && !s_q.w_full) begin
			s_d.w_full = 1'b1;
			s_d.w_data = S_AXI_WDATA_I;
			s_d.w_strb = S_AXI_WSTRB_I;
		end
		if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
			wr_fire     = 1'b1;
			s_d.aw_full = 1'b0;
			s_d.w_full  = 1'b0;
			s_d.bvalid  = 1'b1;
		end
		if (s_q.bvalid && S_AXI_BREADY_I) begin
			s_d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			case ({s_q.aw_addr[7:2], 2'b00})
				OFS_ADDR: begin
					wval       = merge({8'h00, s_q.addr}, s_q.w_data, s_q.w_strb);
					s_d.addr   = wval[ADDR_W-1:0];
				end
				OFS_WDATA: begin
					wval       = merge({16'h0000, s_q.wdata}, s_q.w_data, s_q.w_strb);
					s_d.wdata  = wval[DATA_W-1:0];
				end
				OFS_CMD: begin
					if (!s_q.go && (s_q.ph == PH_IDLE) && s_q.w_strb[0]) begin
						s_d.go  = 1'b1;
						s_d.dir = s_q.w_data[CMD_DIR_BIT];
						s_d.cs  = s_q.w_data[CMD_CS_LSB +: 2];
					end
				end
				OFS_STATUS: begin
					// A completion in this same cycle keeps the flag set
					if (s_q.w_strb[0] && s_q.w_data[ST_DONE_BIT] && !(s_d.done && !s_q.done)) begin
						s_d.done = 1'b0;
					end
				end
				default: begin
					if ((s_q.aw_addr >= OFS_TCFG0) && (s_q.aw_addr <= OFS_TCFG3)) begin
						wval = merge({19'h0, s_q.tcfg[s_q.aw_addr[3:2]]},
							s_q.w_data, s_q.w_strb);
						s_d.tcfg[s_q.aw_addr[3:2]] = wval[CFG_W-1:0];
					end else begin
						wmap = 1'b0;
					end
				end
			endcase
			s_d.bresp = wmap ? RESP_OK : RESP_ERR;
		end

		// ======================================================
		// AXI4-Lite read channel
		if (S_AXI_ARVALID_I && !s_q.rvalid) begin
			case ({S_AXI_ARADDR_I[7:2], 2'b00})
				OFS_ADDR:   rval = {8'h00, s_q.addr};
				OFS_WDATA:  rval = {16'h0000, s_q.wdata};
				OFS_CMD:    rval = {29'h0, s_q.cs, s_q.dir};
				OFS_STATUS: rval = {30'h0, s_q.done, s_q.go || (s_q.ph != PH_IDLE)};
				OFS_RDATA:  rval = {16'h0000, s_q.rdata};
				default: begin
					if ((S_AXI_ARADDR_I >= OFS_TCFG0) && (S_AXI_ARADDR_I <= OFS_TCFG3)) begin
						rval = {19'h0, s_q.tcfg[S_AXI_ARADDR_I[3:2]]};
					end else begin
						rmap = 1'b0;
					end
				end
			endcase
			s_d.rvalid    = 1'b1;
			s_d.rdata_bus = rval;
			s_d.rresp     = rmap ? RESP_OK : RESP_ERR;
		end else if (s_q.rvalid && S_AXI_RREADY_I) begin
			s_d.rvalid = 1'b0;
		end

		// Ready flags registered from slot state
		s_d.aw_rdy = !s_d.aw_full;
		s_d.w_rdy  = !s_d.w_full;
		s_d.ar_rdy = !s_d.rvalid;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			s_q        <= '0;
			s_q.ph     <= PH_IDLE;
			s_q.tcfg   <= {NUM_CS{TCFG_RST}};
			s_q.p_rd_n <= 1'b1;
			s_q.p_wr_n <= 1'b1;
			s_q.p_cs_n <= '1;
			s_q.aw_rdy <= 1'b1;
			s_q.w_rdy  <= 1'b1;
			s_q.ar_rdy <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs
	assign S_AXI_AWREADY_O = s_q.aw_rdy;
	assign S_AXI_WREADY_O  = s_q.w_rdy;
	assign S_AXI_BVALID_O  = s_q.bvalid;
	assign S_AXI_BRESP_O   = s_q.bresp;
	assign S_AXI_ARREADY_O = s_q.ar_rdy;
	assign S_AXI_RVALID_O  = s_q.rvalid;
	assign S_AXI_RDATA_O   = s_q.rdata_bus;
	assign S_AXI_RRESP_O   = s_q.rresp;
	assign BUS_REF_CLK_O   = s_q.ref_clk;
	assign BUS_ADDR_O      = s_q.p_addr;
	assign BUS_DATA_O      = s_q.p_data;
	assign BUS_DATA_OE_O   = s_q.p_oe;
	assign BUS_RD_N_O      = s_q.p_rd_n;
	assign BUS_WR_N_O      = s_q.p_wr_n;
	assign BUS_ALE_O       = s_q.p_ale;
	assign BUS_CS_N_O      = s_q.p_cs_n;

endmodule

// ==== verilog/ebcp_pkg.sv ====
// Purpose: Constants and types for the external bus cycle phaser
// Assumes: 125 MHz MCLK_I, AXI4-Lite register access, 16-bit bus data
// Notes:   One cpu_clock_period equals one bus_reference_clock_out period
package ebcp_pkg;

	// ==========================================================
	// Bus geometry
	localparam int unsigned AXI_AW   = 8;
	localparam int unsigned ADDR_W   = 24;
	localparam int unsigned DATA_W   = 16;
	localparam int unsigned NUM_CS   = 4;
	localparam int unsigned CFG_W    = 13;
	localparam int unsigned SYNC_W   = 16;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_ADDR   = 8'h00;
	localparam logic [7:0] OFS_WDATA  = 8'h04;
	localparam logic [7:0] OFS_CMD    = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_RDATA  = 8'h10;
	localparam logic [7:0] OFS_TCFG0  = 8'h20;
	localparam logic [7:0] OFS_TCFG3  = 8'h2c;

	// ==========================================================
	// Field positions
	localparam int unsigned CMD_DIR_BIT   = 0;
	localparam int unsigned CMD_CS_LSB    = 1;
	localparam int unsigned ST_BUSY_BIT   = 0;
	localparam int unsigned ST_DONE_BIT   = 1;
	localparam int unsigned CFG_AB_BIT    = 0;
	localparam int unsigned CFG_ABX_LSB   = 1;
	localparam int unsigned CFG_C_LSB     = 3;
	localparam int unsigned CFG_D_BIT     = 5;
	localparam int unsigned CFG_E_LSB     = 6;
	localparam int unsigned CFG_F_LSB     = 11;

	// ==========================================================
	// Reset values and response codes
	localparam logic [CFG_W-1:0] TCFG_RST = 13'h1fff;
	localparam logic [1:0]       RESP_OK  = 2'h0;
	localparam logic [1:0]       RESP_ERR = 2'h2;

	// ==========================================================
	// Timing: ref clock is MCLK divided by this, one period is one CPU_CLOCK_PERIOD
	localparam int unsigned MCLK_PERIOD_NS = 8;
	localparam int unsigned TCP_NS         = 16;
	localparam int unsigned TCP_CYCLES     = TCP_NS / MCLK_PERIOD_NS;

	// ==========================================================
	// Cycle phases
	typedef enum logic [5:0] {
		PH_IDLE = 6'b000001,
		PH_AB   = 6'b000010,
		PH_C    = 6'b000100,
		PH_D    = 6'b001000,
		PH_E    = 6'b010000,
		PH_F    = 6'b100000
	} ebcp_phase_t;

endpackage

// ==== verilog/ebcp_sync.sv ====
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_i
// Notes:   Output changes only when stages two and three agree
module ebcp_sync #(
	parameter int unsigned W = 16
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	// ==========================================================
	// Stages
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			out_q <= '0;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				out_q <= s3_q;
			end
		end
	end

	assign sync_o = out_q;

endmodule
